// ==== fvg_pkg.sv ====
package fvg_pkg;

    // ------------------------------------------------------------
    // Register addresses on the CPU bus.
    // ------------------------------------------------------------
    localparam logic [15:0] CTRL_ADDR = 16'hff80;
    localparam logic [15:0] EBLK_A_ADDR = 16'hff82;
    localparam logic [15:0] EBLK_B_ADDR = 16'hff83;

    // ------------------------------------------------------------
    // Control register layout and values.
    // ------------------------------------------------------------
    localparam int CTRL_SUPPLY_BIT = 7;
    localparam int CTRL_ERASE_BIT = 1;
    localparam int CTRL_PROG_BIT = 0;
    localparam logic [7:0] CTRL_RESET = 8'h80;
    localparam logic [7:0] RESERVED_READ = 8'hff;
    localparam logic [7:0] EBLK_RESET = 8'h00;

    // ------------------------------------------------------------
    // Programmer address space.
    // ------------------------------------------------------------
    localparam int PROG_ADDR_W = 17;
    localparam int ARRAY_BYTES_DEF = 32768;

    // ------------------------------------------------------------
    // Bundled CPU bus request.
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } fvg_cpu_req_t;

endpackage

// ==== fvg_flash_gate.sv ====
`timescale 1ns/1ps

// What this block does
// - Control and erase registers reachable only with high supply.
// - With high supply, control reads/writes; reset 80h.
// - Without high supply, control ignores writes, reads FFh.
// - Flag follows supply threshold comparator, not software.
// - Flag set permits writes before full voltage.
// - Flash reads unreliable during supply transition.
// - Programmer addresses above array read FFh.
// - Program bit held set defines programming pulse.
module fvg_flash_gate #(
    parameter int ARRAY_BYTES = fvg_pkg::ARRAY_BYTES_DEF
) (
    input wire logic clock,
    input wire logic rst,
    input wire fvg_pkg::fvg_cpu_req_t cpu_req,
    output logic [7:0] cpu_rdata,
    output logic cpu_rvalid,
    input wire logic program_supply_pin_high,
    output logic supply_high_flag,
    output logic flash_read_hold,
    output logic flash_prog_pulse,
    output logic flash_erase_pulse,
    output logic [7:0] erase_block_select_a,
    output logic [7:0] erase_block_select_b,
    input wire logic [fvg_pkg::PROG_ADDR_W-1:0] prog_addr,
    input wire logic prog_rd,
    input wire logic [7:0] array_rdata,
    output logic [7:0] prog_rdata
);

    // Refuse an array size that the programmer space cannot hold.
    if (ARRAY_BYTES < 1
        || ARRAY_BYTES > (1 << fvg_pkg::PROG_ADDR_W)) begin : g_bad_size
        $error("ARRAY_BYTES does not fit the programmer space.");
    end

    // ------------------------------------------------------------
    // Supply comparator synchroniser and flag.
    // ------------------------------------------------------------
    logic sync1_reg;
    logic sync2_reg;
    logic sync3_reg;
    logic flag_reg;
    logic hold_reg;

    // Three stages; the flag moves only when stages two and three agree.
    always_ff @(posedge clock) begin
        if (rst) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            sync3_reg <= 1'b0;
        end else begin
            sync1_reg <= program_supply_pin_high;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // The flag tracks the comparator alone; software cannot touch it.
    always_ff @(posedge clock) begin
        if (rst) begin
            flag_reg <= 1'b0;
        end else if (sync2_reg == sync3_reg) begin
            flag_reg <= sync3_reg;
        end
    end

    // Flash reads are flagged unsafe while the supply is moving.
    always_ff @(posedge clock) begin
        if (rst) begin
            hold_reg <= 1'b0;
        end else begin
            hold_reg <= (sync2_reg != sync3_reg) || (sync3_reg != flag_reg);
        end
    end

    // ------------------------------------------------------------
    // Register file, gated by the flag of the current cycle.
    // ------------------------------------------------------------
    logic prog_reg;
    logic erase_reg;
    logic [7:0] eblk_a_reg;
    logic [7:0] eblk_b_reg;
    logic wr_ctrl;
    logic wr_eblk_a;
    logic wr_eblk_b;

    // Writes land only while the flag is set, even below full voltage.
    assign wr_ctrl = cpu_req.wr && cpu_req.addr == fvg_pkg::CTRL_ADDR
        && flag_reg;
    assign wr_eblk_a = cpu_req.wr && cpu_req.addr == fvg_pkg::EBLK_A_ADDR
        && flag_reg;
    assign wr_eblk_b = cpu_req.wr && cpu_req.addr == fvg_pkg::EBLK_B_ADDR
        && flag_reg;

    // Pulse bits drop with the flag so a lost supply stops any pulse.
    always_ff @(posedge clock) begin
        if (rst || !flag_reg) begin
            prog_reg <= fvg_pkg::CTRL_RESET[fvg_pkg::CTRL_PROG_BIT];
            erase_reg <= fvg_pkg::CTRL_RESET[fvg_pkg::CTRL_ERASE_BIT];
        end else if (wr_ctrl) begin
            prog_reg <= cpu_req.wdata[fvg_pkg::CTRL_PROG_BIT];
            erase_reg <= cpu_req.wdata[fvg_pkg::CTRL_ERASE_BIT];
        end
    end

    // Erase block selections.
    always_ff @(posedge clock) begin
        if (rst) begin
            eblk_a_reg <= fvg_pkg::EBLK_RESET;
            eblk_b_reg <= fvg_pkg::EBLK_RESET;
        end else begin
            if (wr_eblk_a) begin
                eblk_a_reg <= cpu_req.wdata;
            end
            if (wr_eblk_b) begin
                eblk_b_reg <= cpu_req.wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // CPU read path, one cycle after the read strobe.
    // ------------------------------------------------------------
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic rvalid_reg;

    // Without the flag every address of the block is a reserved byte.
    always_comb begin
        rdata_next = fvg_pkg::RESERVED_READ;
        if (flag_reg) begin
            case (cpu_req.addr)
                fvg_pkg::CTRL_ADDR: begin
                    rdata_next = 8'h00;
                    rdata_next[fvg_pkg::CTRL_SUPPLY_BIT] = 1'b1;
                    rdata_next[fvg_pkg::CTRL_ERASE_BIT] = erase_reg;
                    rdata_next[fvg_pkg::CTRL_PROG_BIT] = prog_reg;
                end
                fvg_pkg::EBLK_A_ADDR: begin
                    rdata_next = eblk_a_reg;
                end
                fvg_pkg::EBLK_B_ADDR: begin
                    rdata_next = eblk_b_reg;
                end
                default: begin
                    rdata_next = fvg_pkg::RESERVED_READ;
                end
            endcase
        end
    end

    // Latch the answer and mark it valid for one cycle.
    always_ff @(posedge clock) begin
        if (rst) begin
            rdata_reg <= 8'h00;
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= cpu_req.rd;
            if (cpu_req.rd) begin
                rdata_reg <= rdata_next;
            end
        end
    end

    // ------------------------------------------------------------
    // Pulse outputs and programmer read path.
    // ------------------------------------------------------------
    logic prog_pulse_reg;
    logic erase_pulse_reg;
    logic [7:0] prog_rdata_reg;

    // The array programs only while the program bit stays set.
    always_ff @(posedge clock) begin
        if (rst) begin
            prog_pulse_reg <= 1'b0;
            erase_pulse_reg <= 1'b0;
        end else begin
            prog_pulse_reg <= prog_reg && flag_reg;
            erase_pulse_reg <= erase_reg && flag_reg;
        end
    end

    // Space above the implemented array reads as erased bytes.
    always_ff @(posedge clock) begin
        if (rst) begin
            prog_rdata_reg <= fvg_pkg::RESERVED_READ;
        end else if (prog_rd) begin
            if (32'(prog_addr) >= ARRAY_BYTES) begin
                prog_rdata_reg <= fvg_pkg::RESERVED_READ;
            end else begin
                prog_rdata_reg <= array_rdata;
            end
        end
    end

    assign cpu_rdata = rdata_reg;
    assign cpu_rvalid = rvalid_reg;
    assign supply_high_flag = flag_reg;
    assign flash_read_hold = hold_reg;
    assign flash_prog_pulse = prog_pulse_reg;
    assign flash_erase_pulse = erase_pulse_reg;
    assign erase_block_select_a = eblk_a_reg;
    assign erase_block_select_b = eblk_b_reg;
    assign prog_rdata = prog_rdata_reg;

    // ------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    gated_read_a: assert property (
        cpu_req.rd && cpu_req.addr == fvg_pkg::CTRL_ADDR && !flag_reg
        |=> cpu_rdata == 8'hff && cpu_rvalid)
        else $error("Control read without flag not FFh.");

    ctrl_read_a: assert property (
        cpu_req.rd && cpu_req.addr == fvg_pkg::CTRL_ADDR && flag_reg
        |=> cpu_rdata[7:2] == 6'h20 && cpu_rdata[0] == $past(prog_reg)
        && cpu_rdata[1] == $past(erase_reg))
        else $error("Control read with flag has wrong value.");

    ebr_write_a: assert property (
        cpu_req.wr && cpu_req.addr == fvg_pkg::EBLK_A_ADDR && flag_reg
        |=> erase_block_select_a == $past(cpu_req.wdata))
        else $error("Block select write with flag lost.");

    ebr_hold_a: assert property (
        cpu_req.wr && cpu_req.addr == fvg_pkg::EBLK_B_ADDR && !flag_reg
        |=> $stable(erase_block_select_b))
        else $error("Block select changed without flag.");

    ctrl_write_a: assert property (
        cpu_req.wr && cpu_req.addr == fvg_pkg::CTRL_ADDR && flag_reg
        && cpu_req.wdata[0] ##1 flag_reg |-> ##1 flash_prog_pulse)
        else $error("Program bit write did not start pulse.");

    flag_follow_a: assert property (
        sync3_reg && sync2_reg ##1 sync3_reg && sync2_reg
        |-> supply_high_flag)
        else $error("Flag did not follow settled supply.");

    read_hold_a: assert property (
        sync2_reg != sync3_reg |=> flash_read_hold)
        else $error("Read hold missing in supply transition.");

    pulse_stop_a: assert property (
        !flag_reg |=> !flash_prog_pulse ##1 !flash_prog_pulse)
        else $error("Program pulse ran without flag.");

    prog_blank_a: assert property (
        prog_rd && 32'(prog_addr) >= ARRAY_BYTES |=> prog_rdata == 8'hff)
        else $error("Programmer read above array not FFh.");

endmodule

// ==== fvg_supply_model.sv ====
`timescale 1ns/1ps

// ------------------------------------------------------------
// Programming supply seen from the pin side.
// ------------------------------------------------------------
module fvg_supply_model (
    input wire logic clock,
    input wire logic want_high,
    output logic program_supply_pin_high
);
    initial program_supply_pin_high = 1'b0;

    // The pin follows the bench request at every falling clock edge.
    always @(negedge clock) begin
        program_supply_pin_high <= want_high;
    end
endmodule

// ==== fvg_flash_gate_bench.sv ====
`timescale 1ns/1ps

`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin \
    bad_count++; $display("BAD t=%0t got=%h exp=%h", $time, got, exp); \
end end

module fvg_flash_gate_bench;
    logic clock, rst, want_high, pin, prog_rd, flag, hold, ppulse, epulse;
    logic rvalid;
    fvg_pkg::fvg_cpu_req_t cpu_req;
    logic [7:0] rdata, ebs_a, ebs_b, array_rdata, prog_rdata;
    logic [16:0] prog_addr;
    int bad_count, checked, cycles;
    logic saw_hold;

    // ------------------------------------------------------------
    // Clock, partner and device.
    // ------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    fvg_supply_model i_fvg_supply_model (.clock(clock),
        .want_high(want_high), .program_supply_pin_high(pin));

    fvg_flash_gate i_fvg_flash_gate (.clock(clock), .rst(rst),
        .cpu_req(cpu_req), .cpu_rdata(rdata), .cpu_rvalid(rvalid),
        .program_supply_pin_high(pin), .supply_high_flag(flag),
        .flash_read_hold(hold), .flash_prog_pulse(ppulse),
        .flash_erase_pulse(epulse), .erase_block_select_a(ebs_a),
        .erase_block_select_b(ebs_b), .prog_addr(prog_addr),
        .prog_rd(prog_rd), .array_rdata(array_rdata),
        .prog_rdata(prog_rdata));

    // ------------------------------------------------------------
    // Bus helpers.
    // ------------------------------------------------------------
    // One CPU access; returns in the cycle where the answer stands.
    task automatic cpu_op(input logic wr, input logic [15:0] a,
                          input logic [7:0] d);
        @(negedge clock);
        cpu_req = '{addr: a, wr: wr, rd: ~wr, wdata: d};
        @(negedge clock);
        cpu_req = '{addr: a, wr: 1'b0, rd: 1'b0, wdata: d};
    endtask

    task automatic rd_exp(input logic [15:0] a, input logic [7:0] e);
        cpu_op(1'b0, a, 8'h00);
        `CHK(rvalid, 1'b1)
        `CHK(rdata, e)
    endtask

    // Waits a bounded time for the flag, noting any transition hold.
    task automatic wait_flag(input logic lvl);
        for (int i = 0; i < 20; i++) begin
            @(negedge clock);
            if (hold === 1'b1) saw_hold = 1'b1;
            if (flag === lvl) break;
        end
        `CHK(flag, lvl)
    endtask

    task automatic prog_op(input logic [16:0] a, input logic [7:0] arr,
                           input logic [7:0] e);
        @(negedge clock);
        prog_addr = a;
        array_rdata = arr;
        prog_rd = 1'b1;
        @(negedge clock);
        prog_rd = 1'b0;
        array_rdata = ~arr;
        `CHK(prog_rdata, e)
    endtask

    // ------------------------------------------------------------
    // Scenarios.
    // ------------------------------------------------------------
    // Without supply every gated address reads reserved; control and block A ignore writes.
    task automatic t_no_supply;
        rd_exp(fvg_pkg::CTRL_ADDR, 8'hff);
        rd_exp(fvg_pkg::EBLK_A_ADDR, 8'hff);
        rd_exp(fvg_pkg::EBLK_B_ADDR, 8'hff);
        cpu_op(1'b1, fvg_pkg::CTRL_ADDR, 8'h01);
        cpu_op(1'b1, fvg_pkg::EBLK_A_ADDR, 8'h5a);
        rd_exp(fvg_pkg::CTRL_ADDR, 8'hff);
        `CHK(ebs_a, 8'h00)
        `CHK(ppulse, 1'b0)
    endtask

    // Raising the supply opens the control register at its reset value.
    task automatic t_supply_on;
        saw_hold = 1'b0;
        want_high = 1'b1;
        wait_flag(1'b1);
        `CHK(saw_hold, 1'b1)
        rd_exp(fvg_pkg::CTRL_ADDR, 8'h80);
    endtask

    // Block selects and pulse bits take writes while the flag is set.
    task automatic t_writes;
        cpu_op(1'b1, fvg_pkg::EBLK_A_ADDR, 8'h5a);
        cpu_op(1'b1, fvg_pkg::EBLK_B_ADDR, 8'ha5);
        `CHK(ebs_a, 8'h5a)
        `CHK(ebs_b, 8'ha5)
        rd_exp(fvg_pkg::EBLK_B_ADDR, 8'ha5);
        cpu_op(1'b1, fvg_pkg::CTRL_ADDR, 8'h01);
        @(negedge clock);
        `CHK(ppulse, 1'b1)
        rd_exp(fvg_pkg::CTRL_ADDR, 8'h81);
        cpu_op(1'b1, fvg_pkg::CTRL_ADDR, 8'h02);
        @(negedge clock);
        `CHK(epulse, 1'b1)
        `CHK(ppulse, 1'b0)
        cpu_op(1'b1, fvg_pkg::CTRL_ADDR, 8'h00);
    endtask

    // Dropping the supply closes the gate on the next access.
    task automatic t_supply_off;
        saw_hold = 1'b0;
        want_high = 1'b0;
        wait_flag(1'b0);
        `CHK(saw_hold, 1'b1)
        rd_exp(fvg_pkg::CTRL_ADDR, 8'hff);
        rd_exp(fvg_pkg::EBLK_A_ADDR, 8'hff);
        `CHK(epulse, 1'b0)
    endtask

    // Programmer reads pass array data only inside the array.
    task automatic t_programmer;
        prog_op(17'h0_0000, 8'ha5, 8'ha5);
        prog_op(17'h0_7fff, 8'h3c, 8'h3c);
        prog_op(17'h0_8000, 8'h3c, 8'hff);
        prog_op(17'h1_ffff, 8'h00, 8'hff);
    endtask

    // A mid-run reset is held ten clocks before the supply rises.
    task automatic t_reset_supply;
        @(negedge clock);
        rst = 1'b1;
        repeat (10) @(negedge clock);
        `CHK(flag, 1'b0)
        `CHK(ebs_a, fvg_pkg::EBLK_RESET)
        want_high = 1'b1;
        repeat (4) @(negedge clock);
        `CHK(flag, 1'b0)
        rst = 1'b0;
        wait_flag(1'b1);
        rd_exp(fvg_pkg::CTRL_ADDR, 8'h80);
        rd_exp(fvg_pkg::EBLK_A_ADDR, fvg_pkg::EBLK_RESET);
    endtask

    // ------------------------------------------------------------
    // Verdict and run control.
    // ------------------------------------------------------------
    task automatic tally_and_finish;
        if (bad_count == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Cuts a hang short well beyond the fewer than a hundred cycles needed.
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            tally_and_finish();
        end
    end

    // Main sequence with a two-cycle reset at the start.
    initial begin
        rst = 1'b1;
        want_high = 1'b0;
        cpu_req = '0;
        prog_addr = '0;
        prog_rd = 1'b0;
        array_rdata = 8'h00;
        repeat (2) @(negedge clock);
        rst = 1'b0;
        t_no_supply();
        t_supply_on();
        t_writes();
        t_supply_off();
        t_programmer();
        t_reset_supply();
        tally_and_finish();
    end
endmodule
